// File: rtl/cmb_cfg.svh
// Address map, field positions and reset values of the CAN message buffering block.
`ifndef CMB_CFG_SVH
`define CMB_CFG_SVH
`define CMB_OFS_CTRL    8'h00
`define CMB_OFS_RXFLAG  8'h04
`define CMB_OFS_TXEMPTY 8'h08
`define CMB_OFS_ABORT   8'h0C
`define CMB_OFS_LOCAL_PRIORITY    8'h10
`define CMB_OFS_TXERR   8'h14
`define CMB_OFS_IDAC    8'h18
`define CMB_OFS_IDMR    8'h1C
`define CMB_OFS_FG0     8'h20
`define CMB_OFS_FG1     8'h24
`define CMB_OFS_FG2     8'h28
`define CMB_OFS_FG3     8'h2C
`define CMB_CTRL_INIT_REQUEST 0
`define CMB_CTRL_SLEEP_REQUEST  1
`define CMB_CTRL_INIT_ACKNOWLEDGE 2
`define CMB_CTRL_SLEEP_ACKNOWLEDGE  3
`define CMB_CTRL_TSEN   4
`define CMB_CTRL_RXIE   5
`define CMB_CTRL_TXIE   8
`define CMB_RXF_BIT     0
`define CMB_OVR_BIT     1
`define CMB_ABAK_POS    8
`define CMB_IDE_BIT     3
`define CMB_TXE_RST     3'h7
`define CMB_MSG_BYTES   4'hF
`define CMB_STAMP_HI    13
`define CMB_STAMP_LO    14
`define CMB_FIFO_LAST   3'h4
`endif

// File: rtl/cmb_fifo_if.sv
// Carrier between the buffering core and its receive FIFO.
`timescale 1ns/1ps
`default_nettype none
interface cmb_fifo_if;
   import cmb_pkg::*;
   logic     push;
   logic     pop;
   cmb_msg_t wdata;
   cmb_msg_t rdata;
   logic     full;
   logic     empty;
   modport ctl (output push, output pop, output wdata, input rdata, input full, input empty);
   modport mem (input push, input pop, input wdata, output rdata, output full, output empty);
endinterface
`default_nettype wire

// File: rtl/cmb_pkg.sv
// Types shared by the CAN message buffering block.
package cmb_pkg;
   typedef logic [7:0]         cmb_byte_t;
   typedef cmb_byte_t [14:0]   cmb_msg_t;
   typedef cmb_byte_t [3:0]    cmb_id4_t;
   typedef cmb_byte_t [2:0]    cmb_local_priority_t;
endpackage

// File: rtl/cmb_rx_fifo.sv
// Five-stage receive FIFO whose head is the foreground buffer.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_cfg.svh"
module cmb_rx_fifo (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   cmb_fifo_if.mem  f
);
   import cmb_pkg::*;
   typedef struct packed {
      cmb_msg_t [4:0] mem;
      logic [2:0]     wp;
      logic [2:0]     rp;
      logic [2:0]     cnt;
   } cmb_fifo_s;
   cmb_fifo_s r_reg;
   cmb_fifo_s r_next;

   function automatic logic [2:0] cmb_inc(input logic [2:0] p);
      cmb_inc = (p == `CMB_FIFO_LAST) ? 3'h0 : p + 3'h1;
   endfunction

   assign f.full  = (r_reg.cnt == `CMB_FIFO_LAST + 3'h1);
   assign f.empty = (r_reg.cnt == 3'h0);
   assign f.rdata = r_reg.mem[r_reg.rp];

   always_comb begin
      r_next = r_reg;
      if (f.push && !f.full) begin
         r_next.mem[r_reg.wp] = f.wdata;
         r_next.wp = cmb_inc(r_reg.wp);
      end
      if (f.pop && !f.empty) begin
         r_next.rp = cmb_inc(r_reg.rp);
      end
      r_next.cnt = r_reg.cnt + 3'((f.push && !f.full) ? 1 : 0) - 3'((f.pop && !f.empty) ? 1 : 0);
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end
endmodule
`default_nettype wire

// File: rtl/cmb_top.sv
// CAN message buffering: transmit scheduling, abort, receive filter and FIFO, AHB-Lite registers.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_cfg.svh"
module cmb_top (
   input  wire logic         SYS_CLK,
   input  wire logic         RST_N,
   input  wire logic         HSEL,
   input  wire logic [31:0]  HADDR,
   input  wire logic [1:0]   HTRANS,
   input  wire logic         HWRITE,
   input  wire logic [2:0]   HSIZE,
   input  wire logic [31:0]  HWDATA,
   input  wire logic         HREADY,
   output logic              HREADYOUT,
   output logic [31:0]       HRDATA,
   output logic              HRESP,
   input  wire logic         RX_SOF,
   input  wire logic         RX_BYTE_VALID,
   input  wire cmb_pkg::cmb_byte_t RX_BYTE,
   input  wire logic         RX_EOM,
   input  wire logic [7:0]   TX_ERR_COUNT,
   input  wire logic         TX_ARB,
   input  wire logic         TX_DONE,
   input  wire logic         TX_ERR,
   output logic              TX_REQ,
   output logic              TX_ACTIVE,
   output logic [1:0]        TX_SEL,
   output logic              TX_IRQ,
   output logic              RX_IRQ
);
   import cmb_pkg::*;

   typedef struct packed {
      logic        init_rq;
      logic        init_ak;
      logic        slp_rq;
      logic        slp_ak;
      logic        ts_en;
      logic        rxie;
      logic [2:0]  txie;
      logic        receiver_full_flag;
      logic        ovr;
      logic [2:0]  tx_buffer_empty;
      logic [2:0]  abrq;
      logic [2:0]  abak;
      cmb_local_priority_t   local_priority;
      logic        in_tx;
      logic [1:0]  sel;
      cmb_id4_t    code;
      cmb_id4_t    mask;
      cmb_msg_t    bg;
      logic [3:0]  bidx;
      logic        mm01;
      logic        mm23;
      logic [15:0] stamp;
      logic [7:0]  tec_rd;
      logic [31:0] hrdata;
      logic        dp_wr;
      logic [7:0]  dp_addr;
   } cmb_state_s;

   cmb_state_s    r_reg;
   cmb_state_s    r_next;
   cmb_fifo_if    fif ();
   logic          in_init;
   logic          mode_ok;
   logic [2:0]    pend;
   logic [1:0]    pick;
   logic          accepted;
   logic          push;
   logic          pop;
   cmb_msg_t      stamped;

   cmb_rx_fifo cmb_rx_fifo_i (
      .SYS_CLK (SYS_CLK),
      .RST_N   (RST_N),
      .f       (fif.mem)
   );

   // A set bit in the mask makes that identifier bit a don't-care.
   function automatic logic cmb_miss(input cmb_byte_t b, input cmb_byte_t c, input cmb_byte_t m);
      cmb_miss = |((b ^ c) & ~m);
   endfunction

   // Lowest value wins; strict compare keeps the lower index on a tie.
   function automatic logic [1:0] cmb_pick(input logic [2:0] p, input cmb_local_priority_t pr);
      logic [1:0] best;
      logic       found;
      best  = 2'h0;
      found = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (p[i] && (!found || pr[i] < pr[best])) begin
            best  = 2'(i);
            found = 1'b1;
         end
      end
      cmb_pick = best;
   endfunction

   function automatic logic [31:0] cmb_fg_word(input cmb_msg_t m, input logic [1:0] w);
      logic [31:0] v;
      v = 32'h0;
      for (int k = 0; k < 4; k++) begin
         if (4 * w + k < int'(`CMB_MSG_BYTES)) begin
            v[8 * k +: 8] = m[4 * w + k];
         end
      end
      cmb_fg_word = v;
   endfunction

   function automatic logic [31:0] cmb_read(input logic [7:0] a, input cmb_state_s s, input cmb_msg_t fg);
      logic [31:0] v;
      v = 32'h0;
      case (a)
         `CMB_OFS_CTRL: begin
            v[`CMB_CTRL_INIT_REQUEST] = s.init_rq;
            v[`CMB_CTRL_SLEEP_REQUEST]  = s.slp_rq;
            v[`CMB_CTRL_INIT_ACKNOWLEDGE] = s.init_ak;
            v[`CMB_CTRL_SLEEP_ACKNOWLEDGE]  = s.slp_ak;
            v[`CMB_CTRL_TSEN]   = s.ts_en;
            v[`CMB_CTRL_RXIE]   = s.rxie;
            v[`CMB_CTRL_TXIE +: 3] = s.txie;
         end
         `CMB_OFS_RXFLAG: begin
            v[`CMB_RXF_BIT] = s.receiver_full_flag;
            v[`CMB_OVR_BIT] = s.ovr;
         end
         `CMB_OFS_TXEMPTY: v[2:0] = s.tx_buffer_empty;
         `CMB_OFS_ABORT: begin
            v[2:0] = s.abrq;
            v[`CMB_ABAK_POS +: 3] = s.abak;
         end
         `CMB_OFS_LOCAL_PRIORITY:  v[23:0] = s.local_priority;
         `CMB_OFS_TXERR: v[7:0] = s.tec_rd;
         `CMB_OFS_IDAC:  v = s.code;
         `CMB_OFS_IDMR:  v = s.mask;
         `CMB_OFS_FG0:   v = cmb_fg_word(fg, 2'h0);
         `CMB_OFS_FG1:   v = cmb_fg_word(fg, 2'h1);
         `CMB_OFS_FG2:   v = cmb_fg_word(fg, 2'h2);
         `CMB_OFS_FG3:   v = cmb_fg_word(fg, 2'h3);
         default:        v = 32'h0;
      endcase
      cmb_read = v;
   endfunction

   assign in_init  = r_reg.init_rq && r_reg.init_ak;
   assign mode_ok  = in_init || (r_reg.slp_rq && r_reg.slp_ak);
   assign pend     = ~r_reg.tx_buffer_empty & ~r_reg.abrq;
   assign pick     = cmb_pick(pend, r_reg.local_priority);
   assign accepted = !r_reg.mm01 && (!r_reg.bg[1][`CMB_IDE_BIT] || !r_reg.mm23);

   always_comb begin
      stamped = r_reg.bg;
      if (r_reg.ts_en) begin
         stamped[`CMB_STAMP_HI] = r_reg.stamp[15:8];
         stamped[`CMB_STAMP_LO] = r_reg.stamp[7:0];
      end
   end

   assign fif.push  = push;
   assign fif.pop   = pop;
   assign fif.wdata = stamped;

   always_comb begin
      r_next       = r_reg;
      push         = 1'b0;
      pop          = 1'b0;
      r_next.init_ak = r_reg.init_rq;
      r_next.slp_ak  = r_reg.slp_rq;
      r_next.stamp   = r_reg.stamp + 16'h1;
      // Outside sleep or init the readable copy simply holds its last value.
      if (mode_ok) begin
         r_next.tec_rd = TX_ERR_COUNT;
      end

      // Register writes in the data phase.
      if (r_reg.dp_wr) begin
         case (r_reg.dp_addr)
            `CMB_OFS_CTRL: begin
               r_next.init_rq = HWDATA[`CMB_CTRL_INIT_REQUEST];
               r_next.slp_rq  = HWDATA[`CMB_CTRL_SLEEP_REQUEST];
               r_next.ts_en   = HWDATA[`CMB_CTRL_TSEN];
               r_next.rxie    = HWDATA[`CMB_CTRL_RXIE];
               r_next.txie    = HWDATA[`CMB_CTRL_TXIE +: 3];
            end
            `CMB_OFS_RXFLAG: begin
               if (HWDATA[`CMB_RXF_BIT] && r_reg.receiver_full_flag) begin
                  r_next.receiver_full_flag = 1'b0;
                  pop        = 1'b1;
               end
               if (HWDATA[`CMB_OVR_BIT]) begin
                  r_next.ovr = 1'b0;
               end
            end
            `CMB_OFS_TXEMPTY: begin
               r_next.tx_buffer_empty  = r_reg.tx_buffer_empty & ~HWDATA[2:0];
               r_next.abak = r_reg.abak & ~HWDATA[2:0];
            end
            `CMB_OFS_ABORT: r_next.abrq = r_reg.abrq | (HWDATA[2:0] & ~r_reg.tx_buffer_empty);
            `CMB_OFS_LOCAL_PRIORITY:  r_next.local_priority = HWDATA[23:0];
            `CMB_OFS_IDAC: begin
               if (in_init) begin
                  r_next.code = HWDATA;
               end
            end
            `CMB_OFS_IDMR: begin
               if (in_init) begin
                  r_next.mask = HWDATA;
               end
            end
            default: begin
            end
         endcase
      end

      // The receiver flag group is held cleared throughout init mode.
      if (in_init) begin
         r_next.receiver_full_flag = 1'b0;
         r_next.ovr = 1'b0;
      end else if (!r_reg.receiver_full_flag && !fif.empty) begin
         r_next.receiver_full_flag = 1'b1;
      end

      // Receive: the first 15 bytes go to the background buffer, filtered on the fly.
      if (RX_SOF) begin
         r_next.bidx = 4'h0;
         r_next.mm01 = 1'b0;
         r_next.mm23 = 1'b0;
      end else if (RX_BYTE_VALID && r_reg.bidx < `CMB_MSG_BYTES) begin
         r_next.bg[r_reg.bidx] = RX_BYTE;
         r_next.bidx = r_reg.bidx + 4'h1;
         if (r_reg.bidx < 4'h2) begin
            r_next.mm01 = r_reg.mm01 | cmb_miss(RX_BYTE, r_reg.code[r_reg.bidx[1:0]],
                                                r_reg.mask[r_reg.bidx[1:0]]);
         end else if (r_reg.bidx < 4'h4) begin
            r_next.mm23 = r_reg.mm23 | cmb_miss(RX_BYTE, r_reg.code[r_reg.bidx[1:0]],
                                                r_reg.mask[r_reg.bidx[1:0]]);
         end
      end
      if (RX_EOM && accepted && !in_init) begin
         if (fif.full) begin
            r_next.ovr = 1'b1;
         end else begin
            push = 1'b1;
         end
      end

      // Abort grant; the buffer on the wire is never cancelled.
      for (int i = 0; i < 3; i++) begin
         if (r_reg.abrq[i] && !r_reg.tx_buffer_empty[i] && !(r_reg.in_tx && r_reg.sel == 2'(i))) begin
            r_next.abrq[i] = 1'b0;
            r_next.tx_buffer_empty[i]  = 1'b1;
            r_next.abak[i] = 1'b1;
         end
      end

      // Transmit scheduling at each arbitration, also after an error.
      if (TX_ARB && !r_reg.in_tx && |pend) begin
         r_next.sel   = pick;
         r_next.in_tx = 1'b1;
      end
      if (TX_DONE && r_reg.in_tx) begin
         r_next.in_tx = 1'b0;
         r_next.tx_buffer_empty[r_reg.sel]  = 1'b1;
         r_next.abak[r_reg.sel] = 1'b0;
         r_next.abrq[r_reg.sel] = 1'b0;
      end else if (TX_ERR) begin
         r_next.in_tx = 1'b0;
      end

      // Address phase of the AHB-Lite slave.
      r_next.dp_wr = 1'b0;
      if (HSEL && HTRANS[1] && HREADY) begin
         r_next.dp_wr   = HWRITE;
         r_next.dp_addr = HADDR[7:0];
         if (!HWRITE) begin
            r_next.hrdata = cmb_read(HADDR[7:0], r_reg, fif.rdata);
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         r_reg     <= '0;
         r_reg.tx_buffer_empty <= `CMB_TXE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = r_reg.hrdata;
   assign TX_REQ    = |pend && !r_reg.in_tx;
   assign TX_ACTIVE = r_reg.in_tx;
   assign TX_SEL    = r_reg.sel;
   assign TX_IRQ    = |(r_reg.tx_buffer_empty & r_reg.txie);
   assign RX_IRQ    = r_reg.receiver_full_flag && r_reg.rxie;

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   a_tec_stale: assert property (!mode_ok |=> $stable(r_reg.tec_rd))
      else $error("error count copy changed outside sleep or init");
   a_code_locked: assert property (!in_init |=> $stable(r_reg.code))
      else $error("acceptance code changed outside init");
   a_local_priority_pick: assert property (TX_ARB && !r_reg.in_tx && |pend |=> r_reg.in_tx && r_reg.sel == $past(pick))
      else $error("wrong buffer scheduled");
   a_tie_low: assert property (TX_ARB && !r_reg.in_tx && pend == 3'h3
                               && r_reg.local_priority[0] == r_reg.local_priority[1] |=> r_reg.sel == 2'h0)
      else $error("tie not broken toward lower index");
   a_done_empty: assert property (TX_DONE && r_reg.in_tx |=> r_reg.tx_buffer_empty[$past(r_reg.sel)] && !r_reg.in_tx)
      else $error("sent buffer not marked empty");
   a_ack_empty: assert property ((r_reg.abak & ~r_reg.tx_buffer_empty) == 3'h0)
      else $error("abort acknowledge without empty flag");
   a_live_kept: assert property (r_reg.in_tx && !TX_DONE && !TX_ERR |=> !r_reg.tx_buffer_empty[$past(r_reg.sel)])
      else $error("buffer in transmission was released");
   a_std_filter: assert property (RX_EOM && !r_reg.bg[1][`CMB_IDE_BIT] && !r_reg.mm01
                                  && !fif.full && !in_init |-> push)
      else $error("accepted standard message not stored");
   a_rxf_sets: assert property (push && fif.empty && !r_reg.receiver_full_flag && !r_reg.init_rq && !r_reg.init_ak
                                |=> ##1 (r_reg.receiver_full_flag || r_reg.init_ak))
      else $error("receiver full not set after store");
   a_rxf_zero: assert property (r_reg.dp_wr && r_reg.dp_addr == `CMB_OFS_RXFLAG && !HWDATA[`CMB_RXF_BIT]
                                && r_reg.receiver_full_flag && !in_init |=> r_reg.receiver_full_flag)
      else $error("writing zero cleared receiver full");
   a_abort_grant: assert property (r_reg.abrq[0] && !r_reg.tx_buffer_empty[0] && !(r_reg.in_tx && r_reg.sel == 2'h0)
                                   |=> r_reg.abak[0] && r_reg.tx_buffer_empty[0])
      else $error("abort of idle buffer not granted");
   a_ovr_drop: assert property (RX_EOM && accepted && fif.full && !in_init |=> r_reg.ovr)
      else $error("dropped message did not flag overrun");

   c_tx_done: cover property (TX_DONE && r_reg.in_tx);
   c_abort: cover property (|(r_reg.abak & ~$past(r_reg.abak)));
   c_rx_push: cover property (push);
   c_fifo_full: cover property (fif.full);
   c_sleep: cover property (r_reg.slp_rq && r_reg.slp_ak);
endmodule
`default_nettype wire

// File: tb/cmb_engine_model.sv
// Behavioural protocol engine that feeds received messages and runs transmissions.
`timescale 1ns/1ps
`default_nettype none
module cmb_engine_model
   import cmb_pkg::*;
#(
   parameter cmb_byte_t ERR_COUNT = 8'h5A
) (
   input  wire logic  clk,
   input  wire logic  tx_req,
   output logic       rx_sof,
   output logic       rx_vld,
   output cmb_byte_t  rx_byte,
   output logic       rx_eom,
   output logic       tx_arb,
   output logic       tx_done,
   output logic       tx_err,
   output cmb_byte_t  err_cnt
);
   initial begin
      {rx_sof, rx_vld, rx_eom, tx_arb, tx_done, tx_err} = 6'h00;
      rx_byte = 8'h00;
      err_cnt = ERR_COUNT;
   end
   // Sends one whole message; the byte lane toggles while no byte is offered.
   task automatic send_msg(input cmb_msg_t m);
      @(posedge clk);
      rx_sof <= 1'b1;
      for (int k = 0; k < 15; k++) begin
         @(posedge clk);
         rx_sof  <= 1'b0;
         rx_vld  <= 1'b1;
         rx_byte <= m[k];
      end
      @(posedge clk);
      rx_vld  <= 1'b0;
      rx_byte <= ~m[14];
      @(posedge clk);
      rx_eom <= 1'b1;
      @(posedge clk);
      rx_eom <= 1'b0;
   endtask
   // Arbitrates once the device shows a pending buffer, or after 50 clocks without one.
   task automatic arb();
      int w;
      w = 0;
      do begin
         @(posedge clk);
         w++;
      end while (tx_req !== 1'b1 && w < 50);
      tx_arb <= 1'b1;
      @(posedge clk);
      tx_arb <= 1'b0;
   endtask
   task automatic finish(input logic ok);
      @(posedge clk);
      tx_done <= ok;
      tx_err  <= !ok;
      @(posedge clk);
      tx_done <= 1'b0;
      tx_err  <= 1'b0;
   endtask
   // Moves the engine's error counter at the next edge.
   task automatic set_err(input cmb_byte_t v);
      @(posedge clk);
      err_cnt <= v;
   endtask
endmodule
`default_nettype wire

// File: tb/cmb_top_bench.sv
// Self-checking bench of the CAN message buffering block.
`timescale 1ns/1ps
`default_nettype none
`include "cmb_cfg.svh"
module cmb_top_bench;
   import cmb_pkg::*;
   logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0;
   logic [31:0] haddr = 0, hwdata = 0, rdv;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, rx_sof, rx_vld, rx_eom, tx_arb, tx_done, tx_err;
   logic        tx_req, tx_active, tx_irq, rx_irq;
   logic [31:0] hrdata;
   logic [1:0]  tx_sel;
   cmb_byte_t   rx_byte, err_cnt;
   int          n_errors = 0, total_checks = 0;
   always #2 clk = ~clk;
   cmb_top cmb_top_i (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
      .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
      .HRDATA(hrdata), .HRESP(hresp), .RX_SOF(rx_sof), .RX_BYTE_VALID(rx_vld), .RX_BYTE(rx_byte),
      .RX_EOM(rx_eom), .TX_ERR_COUNT(err_cnt), .TX_ARB(tx_arb), .TX_DONE(tx_done), .TX_ERR(tx_err),
      .TX_REQ(tx_req), .TX_ACTIVE(tx_active), .TX_SEL(tx_sel), .TX_IRQ(tx_irq), .RX_IRQ(rx_irq));
   cmb_engine_model cmb_engine_model_i (.clk(clk), .tx_req(tx_req), .rx_sof(rx_sof), .rx_vld(rx_vld),
      .rx_byte(rx_byte), .rx_eom(rx_eom), .tx_arb(tx_arb), .tx_done(tx_done), .tx_err(tx_err),
      .err_cnt(err_cnt));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      haddr  <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      ahb(1'b1, a, d);
   endtask
   task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      ahb(1'b0, a, 32'h00000000);
      chk(nm, e, rdv & m);
   endtask
   function automatic cmb_msg_t mk(input cmb_byte_t i1, input cmb_byte_t i3, input cmb_byte_t d4);
      cmb_msg_t m;
      for (int k = 0; k < 15; k++) m[k] = 8'h60 + 8'(k);
      m[0] = 8'h11;
      m[1] = i1;
      m[2] = 8'h33;
      m[3] = i3;
      m[4] = d4;
      return m;
   endfunction
   task automatic t_reset();
      rd_chk("acc code", `CMB_OFS_IDAC, 32'h00000000, 32'hFFFFFFFF);
      rd_chk("tx empty", `CMB_OFS_TXEMPTY, 32'h00000007, 32'h00000007);
      rd_chk("rx flags", `CMB_OFS_RXFLAG, 32'h00000000, 32'h00000003);
   endtask
   task automatic t_config();
      wr(`CMB_OFS_IDAC, 32'hFFFFFFFF);
      rd_chk("acc code locked", `CMB_OFS_IDAC, 32'h00000000, 32'hFFFFFFFF);
      wr(`CMB_OFS_CTRL, 32'h00000001);
      repeat (2) @(posedge clk);
      rd_chk("init ack", `CMB_OFS_CTRL, 32'h00000005, 32'h0000000F);
      wr(`CMB_OFS_IDAC, 32'h44332211);
      wr(`CMB_OFS_IDMR, 32'h00000800);
      rd_chk("acc code", `CMB_OFS_IDAC, 32'h44332211, 32'hFFFFFFFF);
      rd_chk("acc mask", `CMB_OFS_IDMR, 32'h00000800, 32'hFFFFFFFF);
      rd_chk("tx err count", `CMB_OFS_TXERR, 32'h0000005A, 32'h000000FF);
      chk("bus response", 32'h0, {31'h0, hresp});
      wr(`CMB_OFS_CTRL, 32'h00000720);
      repeat (2) @(posedge clk);
      cmb_engine_model_i.set_err(8'h33);
      rd_chk("tx err stale", `CMB_OFS_TXERR, 32'h0000005A, 32'h000000FF);
      wr(`CMB_OFS_CTRL, 32'h00000722);
      repeat (2) @(posedge clk);
      rd_chk("tx err sleep", `CMB_OFS_TXERR, 32'h00000033, 32'h000000FF);
      wr(`CMB_OFS_CTRL, 32'h00000720);
      repeat (2) @(posedge clk);
   endtask
   task automatic t_filter();
      cmb_engine_model_i.send_msg(mk(8'h2A, 8'h45, 8'h00));
      cmb_engine_model_i.send_msg(mk(8'h22, 8'h99, 8'hA0));
      repeat (3) @(posedge clk);
      rd_chk("rx full", `CMB_OFS_RXFLAG, 32'h00000001, 32'h00000003);
      chk("rx irq", 32'h1, {31'h0, rx_irq});
      rd_chk("fg id", `CMB_OFS_FG0, 32'h99332211, 32'hFFFFFFFF);
      rd_chk("fg data", `CMB_OFS_FG1, 32'h000000A0, 32'h000000FF);
      rd_chk("fg tail", `CMB_OFS_FG3, 32'h006E6D6C, 32'h00FFFFFF);
      wr(`CMB_OFS_RXFLAG, 32'h00000000);
      rd_chk("rx full kept", `CMB_OFS_RXFLAG, 32'h00000001, 32'h00000003);
      wr(`CMB_OFS_RXFLAG, 32'h00000001);
      repeat (2) @(posedge clk);
      rd_chk("rx full cleared", `CMB_OFS_RXFLAG, 32'h00000000, 32'h00000003);
      chk("rx irq off", 32'h0, {31'h0, rx_irq});
   endtask
   task automatic t_fifo();
      logic [15:0] st, pst, dst;
      pst = 16'h0000;
      wr(`CMB_OFS_CTRL, 32'h00000730);
      for (int i = 0; i < 6; i++) cmb_engine_model_i.send_msg(mk(8'h2A, 8'h44, 8'(i)));
      repeat (3) @(posedge clk);
      rd_chk("fifo overrun", `CMB_OFS_RXFLAG, 32'h00000003, 32'h00000003);
      for (int i = 0; i < 5; i++) begin
         rd_chk("fifo order", `CMB_OFS_FG1, 32'(i), 32'h000000FF);
         // Back-to-back messages end 19 clocks apart, so their stamps differ by that.
         ahb(1'b0, `CMB_OFS_FG3, 32'h00000000);
         st  = {rdv[15:8], rdv[23:16]};
         dst = st - pst;
         if (i > 0) chk("stamp step", 32'h00000013, {16'h0000, dst});
         pst = st;
         wr(`CMB_OFS_RXFLAG, 32'h00000003);
         repeat (2) @(posedge clk);
      end
      rd_chk("fifo drained", `CMB_OFS_RXFLAG, 32'h00000000, 32'h00000003);
   endtask
   task automatic t_tx();
      wr(`CMB_OFS_LOCAL_PRIORITY, 32'h00050510);
      wr(`CMB_OFS_TXEMPTY, 32'h00000007);
      cmb_engine_model_i.arb();
      #1 chk("tie pick", 32'h1, {30'h0, tx_sel});
      chk("tx active", 32'h1, {31'h0, tx_active});
      cmb_engine_model_i.finish(1'b0);
      wr(`CMB_OFS_LOCAL_PRIORITY, 32'h00010510);
      cmb_engine_model_i.arb();
      #1 chk("retry pick", 32'h2, {30'h0, tx_sel});
      cmb_engine_model_i.finish(1'b1);
      repeat (2) @(posedge clk);
      rd_chk("sent empty", `CMB_OFS_TXEMPTY, 32'h00000004, 32'h00000007);
      chk("tx irq", 32'h1, {31'h0, tx_irq});
      cmb_engine_model_i.arb();
      #1 chk("low value pick", 32'h1, {30'h0, tx_sel});
      wr(`CMB_OFS_ABORT, 32'h00000003);
      repeat (2) @(posedge clk);
      rd_chk("abort ack", `CMB_OFS_ABORT, 32'h00000100, 32'h00000700);
      rd_chk("abort empty", `CMB_OFS_TXEMPTY, 32'h00000005, 32'h00000007);
      cmb_engine_model_i.finish(1'b1);
      repeat (2) @(posedge clk);
      rd_chk("active not aborted", `CMB_OFS_ABORT, 32'h00000100, 32'h00000707);
      rd_chk("all empty", `CMB_OFS_TXEMPTY, 32'h00000007, 32'h00000007);
      wr(`CMB_OFS_LOCAL_PRIORITY, 32'h00000505);
      wr(`CMB_OFS_TXEMPTY, 32'h00000003);
      cmb_engine_model_i.arb();
      #1 chk("tie low index", 32'h0, {30'h0, tx_sel});
      cmb_engine_model_i.finish(1'b1);
      repeat (2) @(posedge clk);
      rd_chk("tie sent empty", `CMB_OFS_TXEMPTY, 32'h00000005, 32'h00000007);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_errors++;
      close_out();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_config();
      t_filter();
      t_fifo();
      t_tx();
      close_out();
   end
endmodule
`default_nettype wire
